// ===== tb/interrupt_latch_mask_service_test.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_latch_mask_service_test;
  import ilm_pkg::*;
  logic clk, sys_rst, reg_wr_en, link_port_interrupt_summary, svc_return;
  logic [1:0] reg_sel, reg_op, reg_rd_sel;
  logic [DW-1:0] reg_wr_data, reg_rd_data;
  logic [PRI_W-1:0] irq_pri;
  logic [SEC_W-1:0] irq_sec;
  logic svc_start, svc_active;
  logic [VEC_W-1:0] svc_vector;
  int errors = 0;
  int n_checks = 0;
  int n_svc = 0;
  ilm_core uut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_sel(reg_sel), .reg_op(reg_op), .reg_wr_data(reg_wr_data),
    .reg_rd_sel(reg_rd_sel), .irq_pri(irq_pri), .irq_sec(irq_sec),
    .link_port_interrupt_summary(link_port_interrupt_summary),
    .svc_return(svc_return), .reg_rd_data(reg_rd_data),
    .svc_start(svc_start), .svc_active(svc_active),
    .svc_vector(svc_vector));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a repeated service shows up as an extra start pulse
  always @(negedge clk)
    if (svc_start === 1'b1)
      n_svc++;
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DW-1:0] seen,
    input logic [DW-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // leaves the strobe high so writes run back to back
  task automatic wr(input logic [1:0] sel, op, input logic [DW-1:0] d);
    reg_wr_en = 1'b1;
    reg_sel = sel;
    reg_op = op;
    reg_wr_data = d;
    @(negedge clk);
  endtask
  task automatic rdc(input logic [1:0] sel, input logic [DW-1:0] exp,
    input string what);
    reg_wr_en = 1'b0;
    reg_rd_sel = sel;
    @(negedge clk);
    @(negedge clk);
    chk(what, reg_rd_data, exp);
  endtask
  task automatic svc(input logic [VEC_W-1:0] v, input logic [DW-1:0] mp);
    reg_wr_en = 1'b0;
    for (int i = 0; i < 20 && svc_start !== 1'b1; i++)
      @(negedge clk);
    chk("svc_start", {31'h0, svc_start}, 32'h1);
    if (svc_start !== 1'b1) wrap_up();
    chk("svc_vector", DW'(svc_vector), DW'(v));
    chk("svc_active", {31'h0, svc_active}, 32'h1);
    rdc(SEL_MP, mp, "mask_ptr_in_service");
    chk("svc_vector_held", DW'(svc_vector), DW'(v));
    svc_return = 1'b1;
    @(negedge clk);
    svc_return = 1'b0;
    chk("svc_active_off", {31'h0, svc_active}, 32'h0);
  endtask
  initial
  begin
    {reg_wr_en, reg_sel, reg_op, reg_wr_data, reg_rd_sel} = '0;
    {irq_pri, irq_sec, link_port_interrupt_summary, svc_return} = '0;
    sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    for (int s = 0; s < 4; s++)
      rdc(2'(s), 32'h0000_0000, "reset_value");
    $display("test reset done");
    wr(SEL_MP, OP_WRITE, 32'h0000_8000);
    rdc(SEL_MP, 32'h0000_8000, "mp_no_shift");
    wr(SEL_MP, OP_WRITE, 32'hFFFF_FFFF);
    rdc(SEL_MP, 32'h7FFF_BFFF, "mp_protected");
    wr(SEL_MP, OP_CLR, 32'h0000_8001);
    rdc(SEL_MP, 32'h7FFF_3FFE, "mp_clear");
    link_port_interrupt_summary = 1'b1;
    wr(SEL_MP, OP_WRITE, 32'h0000_0000);
    rdc(SEL_MP, 32'h0000_4000, "mp_summary");
    link_port_interrupt_summary = 1'b0;
    rdc(SEL_MP, 32'h0000_0000, "mp_summary_off");
    wr(SEL_MP, 2'h3, 32'hFFFF_FFFF);
    rdc(SEL_MP, 32'h0000_0000, "mp_op_none");
    $display("test mask pointer done");
    wr(SEL_PRI, OP_SET, 32'h0000_0008);
    wr(SEL_SEC, OP_SET, 32'h0000_0020);
    rdc(SEL_PRI, 32'h0000_0008, "pri_latched");
    rdc(SEL_SEC, 32'h0000_0020, "sec_latched");
    wr(SEL_MASK, OP_WRITE, 32'hFFFF_FFFF);
    svc(5'h03, 32'h0000_0008);
    svc(5'h14, 32'h0010_0000);
    rdc(SEL_PRI, 32'h0000_0000, "pri_serviced");
    rdc(SEL_SEC, 32'h0000_0000, "sec_serviced");
    $display("test priority done");
    irq_pri = 14'h0001;
    @(negedge clk);
    irq_pri = 14'h0000;
    svc(5'h00, 32'h0000_0001);
    $display("test hardware event done");
    // nothing like a debug break is injected right after these writes
    wr(SEL_PRI, OP_SET, 32'h0000_0004);
    wr(SEL_MP, OP_WRITE, 32'h0000_0000);
    svc(5'h02, 32'h0000_0004);
    wr(SEL_PRI, OP_SET, 32'h0000_0002);
    wr(SEL_SEC, OP_SET, 32'h0000_0001);
    svc(5'h01, 32'h0000_0002);
    svc(5'h0F, 32'h0000_8000);
    repeat (10) @(negedge clk);
    rdc(SEL_MP, 32'h0000_0000, "mp_after_return");
    rdc(SEL_MASK, 32'hFFFF_FFFF, "mask_value");
    $display("test coinciding write done");
    // a pend that is latched when reset hits must not survive it
    wr(SEL_PRI, OP_SET, 32'h0000_0002);
    sys_rst = 1'b1;
    reg_wr_en = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int s = 0; s < 4; s++)
      rdc(2'(s), 32'h0000_0000, "reset_again");
    chk("service_count", DW'(n_svc), 32'h6);
    $display("test midrun reset done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== verilog/ilm_core.sv
// Operation
// [R1] mask-pointer bits 0-13 written exactly, no shift
// [R2] bit 14 mirrors link summary, write-protected
// [R3] reserved bit 31 ignores writes
// [R4] highest priority first, then descending order
// [R5] core bit-set of latch requests service
// [R6] debugger avoids breakpoint after latch/pointer writes
// [R7] one service per latch, pointer bit set
`timescale 1ns/1ps
`default_nettype none
module ilm_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic [1:0] reg_sel,
  input wire logic [1:0] reg_op,
  input wire logic [ilm_pkg::DW-1:0] reg_wr_data,
  input wire logic [1:0] reg_rd_sel,
  input wire logic [ilm_pkg::PRI_W-1:0] irq_pri,
  input wire logic [ilm_pkg::SEC_W-1:0] irq_sec,
  input wire logic link_port_interrupt_summary,
  input wire logic svc_return,
  output logic [ilm_pkg::DW-1:0] reg_rd_data,
  output logic svc_start,
  output logic svc_active,
  output logic [ilm_pkg::VEC_W-1:0] svc_vector
);
  import ilm_pkg::*;

  logic [PRI_W-1:0] primary_interrupt_latch_q, pri_d;
  logic [SEC_W-1:0] secondary_interrupt_latch_q, sec_d;
  logic [DW-1:0] interrupt_mask_pointer_q, mp_d;
  logic [DW-1:0] interrupt_mask_q, mask_d;
  ilm_state_t state_q, state_d;
  logic [VEC_W-1:0] cur_q;
  logic svc_start_q;
  logic svc_active_q;
  logic [DW-1:0] rd_q, rd_d;

  // op 3 leaves the register as it is
  function automatic logic [DW-1:0] apply_op(input logic [DW-1:0] old,
    input logic [DW-1:0] data, input logic [1:0] op);
    logic [DW-1:0] r;
    r = old;
    case (op)
      OP_WRITE: r = data;
      OP_SET: r = old | data;
      OP_CLR: r = old & ~data;
      default: r = old;
    endcase
    return r;
  endfunction

  wire wr_pri = reg_wr_en && (reg_sel == SEL_PRI);
  wire wr_sec = reg_wr_en && (reg_sel == SEL_SEC);
  wire wr_mp = reg_wr_en && (reg_sel == SEL_MP);
  wire wr_mask = reg_wr_en && (reg_sel == SEL_MASK);

  wire [DW-1:0] pri_ext = {{(DW-PRI_W){1'b0}}, primary_interrupt_latch_q};
  wire [DW-1:0] sec_ext = {{(DW-SEC_W){1'b0}}, secondary_interrupt_latch_q};
  wire [DW-1:0] pri_wv = wr_pri ? apply_op(pri_ext, reg_wr_data, reg_op)
                                : pri_ext;
  wire [DW-1:0] sec_wv = wr_sec ? apply_op(sec_ext, reg_wr_data, reg_op)
                                : sec_ext;
  wire [DW-1:0] mp_wv = wr_mp ? apply_op(interrupt_mask_pointer_q,
                                         reg_wr_data, reg_op)
                              : interrupt_mask_pointer_q;

  // interrupt n: 0-13 primary, 15-30 secondary, 14 has no source
  wire [NIRQ-1:0] latch_vec = {secondary_interrupt_latch_q, 1'b0,
                               primary_interrupt_latch_q};
  wire [NIRQ-1:0] irq_vec = {irq_sec, 1'b0, irq_pri};
  wire [NIRQ-1:0] pend = latch_vec & interrupt_mask_q[NIRQ-1:0];

  logic pend_found;
  logic [VEC_W-1:0] pend_idx;

  // fixed priority on purpose: a rotating scan would break the ordering
  ilm_prio_enc #(
    .W(NIRQ),
    .IW(VEC_W)
  ) u_prio (
    .req(pend),
    .found(pend_found),
    .index(pend_idx)
  );

  wire take = (state_q == ST_IDLE) && pend_found; // [R4] [R5]
  wire ret = (state_q == ST_SERVE) && svc_return;
  wire [NIRQ-1:0] take_oh = take ? (31'h1 << pend_idx) : '0;
  wire [NIRQ-1:0] ret_oh = ret ? (31'h1 << cur_q) : '0;

  // the taken bit is cleared only if it was already latched, so a core
  // write in the same cycle cannot re-arm it and cause a second service;
  // a fresh hardware event still wins over the clear
  wire [NIRQ-1:0] clr_vec = take_oh & latch_vec; // [R7]
  assign pri_d = (pri_wv[PRI_W-1:0] & ~clr_vec[PRI_W-1:0]) | irq_pri;
  assign sec_d = (sec_wv[SEC_W-1:0] & ~clr_vec[NIRQ-1:SEC_BASE]) | irq_sec;

  // service marking is merged after the write so it survives a
  // coincident full write of the pointer
  wire [NIRQ-1:0] mp_core = (mp_wv[NIRQ-1:0] | take_oh) & ~ret_oh; // [R7]
  assign mp_d = {1'b0, // [R3]
                 mp_core[NIRQ-1:MP_SUM_BIT+1],
                 link_port_interrupt_summary, // [R2]
                 mp_core[MP_SUM_BIT-1:0]}; // [R1]

  assign mask_d = wr_mask ? apply_op(interrupt_mask_q, reg_wr_data, reg_op)
                          : interrupt_mask_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (take)
          state_d = ST_SERVE;
      ST_SERVE:
        if (svc_return)
          state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // busy flag is taken from the next state so it is a plain flop output
  wire serve_next = (state_d == ST_SERVE);

  // registered read: data trails reg_rd_sel by one cycle
  wire [DW-1:0] rd_pri = pri_ext;
  wire [DW-1:0] rd_sec = sec_ext;
  assign rd_d = (reg_rd_sel == SEL_PRI) ? rd_pri :
                (reg_rd_sel == SEL_SEC) ? rd_sec :
                (reg_rd_sel == SEL_MP) ? interrupt_mask_pointer_q :
                interrupt_mask_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      primary_interrupt_latch_q <= PRI_RST;
      secondary_interrupt_latch_q <= SEC_RST;
      interrupt_mask_pointer_q <= MP_RST;
      interrupt_mask_q <= MASK_RST;
      state_q <= ST_IDLE;
      cur_q <= '0;
      svc_start_q <= 1'b0;
      svc_active_q <= 1'b0;
      rd_q <= '0;
    end
    else
    begin
      primary_interrupt_latch_q <= pri_d; // [R5]
      secondary_interrupt_latch_q <= sec_d; // [R5]
      interrupt_mask_pointer_q <= mp_d;
      interrupt_mask_q <= mask_d;
      state_q <= state_d;
      if (take)
        cur_q <= pend_idx;
      svc_start_q <= take;
      svc_active_q <= serve_next;
      rd_q <= rd_d;
    end
  end

  assign reg_rd_data = rd_q;
  assign svc_start = svc_start_q;
  assign svc_active = svc_active_q;
  assign svc_vector = cur_q;

  // checks
  logic [NIRQ-1:0] pend_past_q;
  logic [NIRQ-1:0] irq_past_q;
  always_ff @(posedge clk)
  begin
    pend_past_q <= pend;
    irq_past_q <= irq_vec;
  end
  wire [NIRQ-1:0] higher_mask = (31'h1 << cur_q) - 31'h1;

  a_mp_low_exact: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    (wr_mp && reg_op == OP_WRITE && state_q == ST_IDLE && !take)
    |=> (interrupt_mask_pointer_q[MP_SUM_BIT-1:0]
         == $past(reg_wr_data[MP_SUM_BIT-1:0])))
    else $error("mask pointer low bits not written exactly");
  a_mp_sum_ro: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    wr_mp |=> (interrupt_mask_pointer_q[MP_SUM_BIT]
               == $past(link_port_interrupt_summary)))
    else $error("summary bit changed by write");
  a_mp_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    (wr_mp && reg_wr_data[MP_RSVD_BIT])
    |=> !interrupt_mask_pointer_q[MP_RSVD_BIT])
    else $error("reserved bit took a write");
  a_prio_highest: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    svc_start_q |-> ((pend_past_q & higher_mask) == '0))
    else $error("lower priority serviced first");
  a_bitset_service: assert property (@(posedge clk) // [R5]
    disable iff (sys_rst)
    (wr_pri && reg_op == OP_SET && state_q == ST_IDLE && !take
     && (reg_wr_data[PRI_W-1:0] & interrupt_mask_q[PRI_W-1:0]) != '0)
    |-> ##2 svc_start_q)
    else $error("core bit-set did not request service");
  a_once_marked: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    svc_start_q |-> (interrupt_mask_pointer_q[cur_q]
                     && (!latch_vec[cur_q] || irq_past_q[cur_q])))
    else $error("serviced bit not marked or left latched");
  a_ret_unmarks: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    (ret && !wr_mp) |=> !interrupt_mask_pointer_q[cur_q])
    else $error("pointer bit kept after return");
  // no nesting: a new pend waits until the return edge
  a_no_nesting: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    (svc_active_q && !svc_return) |=> (!svc_start_q && $stable(cur_q)))
    else $error("service started while another was active");
  a_hw_latched: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    (irq_vec != '0) |=> ((latch_vec & $past(irq_vec)) == $past(irq_vec)))
    else $error("hardware event lost against a clear");
  a_mp_op_none: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    (wr_mp && reg_op == 2'h3 && state_q == ST_IDLE && !take)
    |=> (interrupt_mask_pointer_q[MP_SUM_BIT-1:0]
         == $past(interrupt_mask_pointer_q[MP_SUM_BIT-1:0])))
    else $error("no-effect op changed the pointer");

  c_service: cover property (@(posedge clk) disable iff (sys_rst)
    svc_start_q ##[1:20] svc_return);
  c_coincide: cover property (@(posedge clk) disable iff (sys_rst)
    take && (wr_sec || wr_mp));
  c_two_pending: cover property (@(posedge clk) disable iff (sys_rst)
    take && ((pend & ~take_oh) != '0));
  c_hw_relatch: cover property (@(posedge clk) disable iff (sys_rst)
    take && ((irq_vec & take_oh) != '0));
endmodule
`default_nettype wire

// ===== verilog/ilm_pkg.sv
`default_nettype none
package ilm_pkg;
  localparam int DW = 32;
  localparam int PRI_W = 14;
  localparam int SEC_W = 16;
  localparam int SEC_BASE = 15;
  localparam int NIRQ = 31;
  localparam int VEC_W = 5;
  localparam int MP_SUM_BIT = 14;
  localparam int MP_RSVD_BIT = 31;
  localparam logic [DW-1:0] MP_WR_MASK = 32'h7FFF_BFFF;
  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_MP = 2'h2;
  localparam logic [1:0] SEL_MASK = 2'h3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLR = 2'h2;
  localparam logic [PRI_W-1:0] PRI_RST = 14'h0000;
  localparam logic [SEC_W-1:0] SEC_RST = 16'h0000;
  localparam logic [DW-1:0] MP_RST = 32'h0000_0000;
  localparam logic [DW-1:0] MASK_RST = 32'h0000_0000;
  typedef enum logic {ST_IDLE, ST_SERVE} ilm_state_t;
endpackage
`default_nettype wire

// ===== verilog/ilm_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
// lowest index wins: index 0 is the highest priority
module ilm_prio_enc #(
  parameter int W = 31,
  parameter int IW = 5
) (
  input wire logic [W-1:0] req,
  output logic found,
  output logic [IW-1:0] index
);
  always_comb
  begin
    found = 1'b0;
    index = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        index = IW'(i);
      end
    end
  end
endmodule
`default_nettype wire
